// File: design/sfp_core.sv
`default_nettype none
// Function
// - Bits 0,4,5,6 ignore writes, read zero
// - Latch bit changes only by commands or reset, never by status data
// - Latch clear after reset
// - Guard bits writable, kept as nonvolatile
// - Guard pair selects protected range
// - Pin enabled and low blocks status writes
// - Array write needs latch and unguarded address
// - Protect pin never blocks array writes
// - Status read shifts out status byte
// - Status write updates enable and guard bits
// - Status write needs latch, then clears it
// - Two address bytes, top bit dropped
// - Burst address increments, wraps to zero
// - Each byte committed at eighth bit
// - Protected address stops burst write
// - Read data MSB first, input ignored
// - Select rise ends read, output floats
// - Fast read adds one dummy byte
// - Fast read ignores input, ends on select
// - Latch set 06h, latch clear 04h
// - Status/memory opcodes encoded as listed
// - Select rise clears latch after write cmds
// - Unknown opcode ignored until next select
module sfp_core (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic chip_sel_n_pin,
  input  wire logic serial_clock,
  input  wire logic serial_in_pin,
  input  wire logic hw_protect_pin,
  output logic      serial_out_pin,
  output logic      serial_out_oe
);
  import sfp_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic cs_n_s, sck_s, si_s, wp_s;  // Synchronised pin levels
  sfp_sync u_cs (.sys_clk(sys_clk), .srst(srst), .rst_val(1'b1),
                 .din(chip_sel_n_pin), .dout(cs_n_s));
  sfp_sync u_ck (.sys_clk(sys_clk), .srst(srst), .rst_val(1'b0),
                 .din(serial_clock), .dout(sck_s));
  sfp_sync u_si (.sys_clk(sys_clk), .srst(srst), .rst_val(1'b0),
                 .din(serial_in_pin), .dout(si_s));
  sfp_sync u_wp (.sys_clk(sys_clk), .srst(srst), .rst_val(1'b1),
                 .din(hw_protect_pin), .dout(wp_s));

  // ****************************************
  // Edge detection on synchronised levels
  // ****************************************
  logic cs_q, sck_q;  // Previous synchronised levels
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cs_q  <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      cs_q  <= cs_n_s;
      sck_q <= sck_s;
    end
  end
  logic cs_fall, cs_rise, sck_rise, sck_fall, sel;
  assign cs_fall  = cs_q & ~cs_n_s;
  assign cs_rise  = ~cs_q & cs_n_s;
  assign sel      = ~cs_n_s;
  // Edges count only while selected; mode 3 idle-high start is harmless
  assign sck_rise = sel & ~sck_q & sck_s;
  assign sck_fall = sel & sck_q & ~sck_s;

  // ****************************************
  // Frame state
  // ****************************************
  sfp_phase_t  phase, next_phase;
  logic [2:0]  bitc, next_bitc;       // Bits taken in current byte
  logic [7:0]  shin, next_shin;       // Input shifter
  logic [7:0]  opc, next_opc;         // Latched opcode
  logic        abyte, next_abyte;     // Second address byte pending
  logic [14:0] addr, next_addr;       // Array pointer
  logic        latch, next_latch;     // Write latch
  logic        clr_pend, next_clr_pend; // Clear latch at frame end
  // Nonvolatile bits start clear and are never touched by srst
  logic        pin_en = 1'b0;         // Protect pin enable
  logic        next_pin_en;
  logic [1:0]  guard = 2'b00;         // Block guard pair
  logic [1:0]  next_guard;
  logic        halted, next_halted;   // Burst write hit guard
  logic [7:0]  shout, next_shout;     // Output shifter
  logic        load_pend, next_load_pend; // Load memory byte next cycle
  logic        oe, next_oe;
  logic        so, next_so;
  logic        mem_we;
  logic [7:0]  mem_q;
  logic [14:0] mem_addr;              // Write pointer or next read pointer
  logic [7:0]  status;
  logic [7:0]  byte_in;
  logic        byte_done;
  logic        guarded;

  // Status image; fixed bits read zero
  always_comb begin
    status               = SR_RESET;
    status[SR_LATCH_BIT] = latch;
    status[SR_GUARD_LO]  = guard[0];
    status[SR_GUARD_HI]  = guard[1];
    status[SR_PIN_EN]    = pin_en;
  end

  // Range decode of the guard pair
  always_comb begin
    unique case (guard)
      2'b00:   guarded = 1'b0;
      2'b01:   guarded = (addr >= GUARD_QTR);
      2'b10:   guarded = (addr >= GUARD_HALF);
      2'b11:   guarded = 1'b1;
    endcase
  end

  assign byte_in   = {shin[6:0], si_s};
  assign byte_done = sck_rise && (bitc == 3'd7);

  // Read port looks ahead so the fetched byte is ready at load time
  assign mem_addr = mem_we ? addr : next_addr;
  sfp_mem u_mem (.sys_clk(sys_clk), .we(mem_we), .addr(mem_addr),
                 .wdata(byte_in), .rdata(mem_q));

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_phase     = phase;
    next_bitc      = bitc;
    next_shin      = shin;
    next_opc       = opc;
    next_abyte     = abyte;
    next_addr      = addr;
    next_latch     = latch;
    next_clr_pend  = clr_pend;
    next_pin_en    = pin_en;
    next_guard     = guard;
    next_halted    = halted;
    next_shout     = shout;
    next_load_pend = 1'b0;
    next_oe        = oe;
    next_so        = so;
    mem_we         = 1'b0;
    if (sck_rise) begin
      next_bitc = bitc + 3'd1;
      next_shin = byte_in;
    end
    if (load_pend) begin
      next_shout = mem_q;
    end
    if (cs_fall) begin
      // New frame
      next_phase    = SFP_OPC;
      next_bitc     = 3'd0;
      next_clr_pend = 1'b0;
      next_halted   = 1'b0;
      next_oe       = 1'b0;
    end else if (cs_rise || !sel) begin
      // Frame end: float output, apply deferred latch clear
      next_oe = 1'b0;
      if (cs_rise && clr_pend) begin
        next_latch = 1'b0;
      end
      next_clr_pend = 1'b0;
      next_phase    = SFP_IGNORE;
    end else if (byte_done) begin
      unique case (phase)
        SFP_OPC: begin
          next_opc   = byte_in;
          next_abyte = 1'b0;
          unique case (byte_in)
            OP_SET_LATCH: begin
              next_latch = 1'b1;
              next_phase = SFP_IGNORE;
            end
            OP_CLR_LATCH: begin
              next_clr_pend = 1'b1;
              next_phase    = SFP_IGNORE;
            end
            OP_STATUS_RD: begin
              next_shout = status;
              next_phase = SFP_SRD;
            end
            OP_STATUS_WR: next_phase = SFP_SWR;
            OP_MEM_RD, OP_MEM_WR, OP_FAST_RD: next_phase = SFP_ADDR;
            default: next_phase = SFP_IGNORE;
          endcase
        end
        SFP_ADDR: begin
          // High byte first; its top bit is dropped
          if (!abyte) begin
            next_addr[14:8] = byte_in[6:0];
            next_abyte      = 1'b1;
          end else begin
            next_addr[7:0] = byte_in;
            if (opc == OP_MEM_WR) begin
              next_phase    = SFP_WDATA;
              next_clr_pend = 1'b1;
            end else if (opc == OP_FAST_RD) begin
              next_phase = SFP_DUMMY;
            end else begin
              next_phase     = SFP_RDATA;
              next_load_pend = 1'b1;
            end
          end
        end
        SFP_DUMMY: begin
          next_phase     = SFP_RDATA;
          next_load_pend = 1'b1;
        end
        SFP_RDATA: begin
          // Input bits ignored; advance and fetch next byte
          next_addr      = addr + 15'd1;
          next_load_pend = 1'b1;
        end
        SFP_WDATA: begin
          // Commit at eighth bit unless latch or guard forbids
          if (halted || guarded || !latch) begin
            next_halted = halted | guarded;
          end else begin
            mem_we    = 1'b1;
            next_addr = addr + 15'd1;
          end
        end
        SFP_SWR: begin
          // Pin gate only when enabled and pin low
          if (latch && !(pin_en && !wp_s)) begin
            next_pin_en = byte_in[SR_PIN_EN];
            next_guard  = {byte_in[SR_GUARD_HI], byte_in[SR_GUARD_LO]};
          end
          next_clr_pend = 1'b1;
          next_phase    = SFP_IGNORE;
        end
        SFP_SRD, SFP_IGNORE: next_phase = SFP_IGNORE;
      endcase
    end
    // Output shifting on falling clock edges
    if (sel && !cs_fall && sck_fall &&
        (phase == SFP_RDATA || phase == SFP_SRD)) begin
      next_oe    = 1'b1;
      next_so    = shout[7];
      next_shout = {shout[6:0], 1'b0};
    end
  end

  // ****************************************
  // State registers; latch clears at reset
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      phase     <= SFP_IGNORE;
      bitc      <= 3'd0;
      shin      <= 8'h00;
      opc       <= 8'h00;
      abyte     <= 1'b0;
      addr      <= ADDR_ZERO;
      latch     <= 1'b0;
      clr_pend  <= 1'b0;
      halted    <= 1'b0;
      shout     <= 8'h00;
      load_pend <= 1'b0;
      oe        <= 1'b0;
      so        <= 1'b0;
    end else begin
      phase     <= next_phase;
      bitc      <= next_bitc;
      shin      <= next_shin;
      opc       <= next_opc;
      abyte     <= next_abyte;
      addr      <= next_addr;
      latch     <= next_latch;
      clr_pend  <= next_clr_pend;
      halted    <= next_halted;
      shout     <= next_shout;
      load_pend <= next_load_pend;
      oe        <= next_oe;
      so        <= next_so;
    end
  end

  // Nonvolatile bits: no reset so they survive power cycles
  always_ff @(posedge sys_clk) begin
    pin_en <= next_pin_en;
    guard  <= next_guard;
  end

  assign serial_out_pin = so;
  assign serial_out_oe  = oe;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  status_zero_a: assert property (status[0] == 1'b0 &&
      status[6:4] == 3'b000) else $error("fixed status bits nonzero");
  sequence set_cmd_s;
    phase == SFP_OPC && byte_done && !cs_fall && byte_in == OP_SET_LATCH;
  endsequence
  latch_set_a: assert property ($rose(latch) |->
      $past(phase == SFP_OPC && byte_done && byte_in == OP_SET_LATCH))
      else $error("latch set without set command");
  latch_take_a: assert property (set_cmd_s |=> latch)
      else $error("set command did not raise latch");
  guard_write_a: assert property (mem_we |-> !guarded && latch)
      else $error("array write to guarded address");
  full_guard_a: assert property (guard == 2'b11 |-> !mem_we)
      else $error("write with full guard");
  pin_block_a: assert property (phase == SFP_SWR && byte_done &&
      pin_en && !wp_s |=> $stable(guard) && pin_en)
      else $error("status write passed pin guard");
  burst_inc_a: assert property (mem_we |=>
      addr == $past(addr) + 15'd1) else $error("address not advanced");
  halt_hold_a: assert property (halted && phase == SFP_WDATA
      |-> !mem_we) else $error("write after guard hit");
  end_float_a: assert property (cs_rise |=> !oe)
      else $error("output still driven after select rise");
  latch_clear_a: assert property (cs_rise && clr_pend |=> !latch)
      else $error("latch not cleared at frame end");
  ignore_float_a: assert property (phase == SFP_IGNORE &&
      !oe |=> !oe) else $error("output driven in ignore phase");
endmodule
`default_nettype wire

// File: pkg/sfp_pkg.sv
`default_nettype none
package sfp_pkg;
  // Opcodes
  localparam logic [7:0] OP_SET_LATCH   = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH   = 8'h04;
  localparam logic [7:0] OP_STATUS_RD   = 8'h05;
  localparam logic [7:0] OP_STATUS_WR   = 8'h01;
  localparam logic [7:0] OP_MEM_RD      = 8'h03;
  localparam logic [7:0] OP_MEM_WR      = 8'h02;
  localparam logic [7:0] OP_FAST_RD     = 8'h0B;
  // Status register layout
  localparam int         SR_LATCH_BIT   = 1;
  localparam int         SR_GUARD_LO    = 2;
  localparam int         SR_GUARD_HI    = 3;
  localparam int         SR_PIN_EN      = 7;
  localparam logic [7:0] SR_RESET       = 8'h00;
  // Array geometry and guard boundaries
  localparam int         ADDR_W         = 15;
  localparam int         DEPTH          = 32768;
  localparam logic [14:0] GUARD_QTR     = 15'h6000;
  localparam logic [14:0] GUARD_HALF    = 15'h4000;
  localparam logic [14:0] ADDR_LAST     = 15'h7FFF;
  localparam logic [14:0] ADDR_ZERO     = 15'h0000;
  // Frame phases
  typedef enum logic [2:0] {
    SFP_OPC, SFP_ADDR, SFP_DUMMY, SFP_RDATA, SFP_WDATA, SFP_SRD, SFP_SWR,
    SFP_IGNORE
  } sfp_phase_t;
endpackage
`default_nettype wire

// File: design/sfp_sync.sv
`default_nettype none
// Two-flop synchroniser for one pin level
module sfp_sync (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic rst_val,
  input  wire logic din,
  output logic      dout
);
  logic meta;  // First stage, read only by the second
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      // Reset to the pin's idle level so no false edge follows reset
      meta <= rst_val;
      dout <= rst_val;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

// File: design/sfp_mem.sv
`default_nettype none
// Byte array with one write port and one registered read port
module sfp_mem (
  input  wire logic        sys_clk,
  input  wire logic        we,
  input  wire logic [14:0] addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata
);
  import sfp_pkg::*;
  logic [7:0] cells [DEPTH];  // Nonvolatile array image
  // Read returns old data on the write cycle
  always_ff @(posedge sys_clk) begin
    if (we) begin
      cells[addr] <= wdata;
    end
    rdata <= cells[addr];
  end
endmodule
`default_nettype wire

// File: bench/sfp_master.sv
`default_nettype none
// ******************************
// SPI bus master model, mode 0
// ******************************
module sfp_master (
  output logic      chip_sel_n_pin,
  output logic      serial_clock,
  output logic      serial_in_pin,
  input  wire logic serial_out_pin,
  input  wire logic serial_out_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 80; // Half of the 160 ns link period
  // Idle bus: deselected, clock parked low between frames
  initial begin
    chip_sel_n_pin = 1'b1;
    serial_clock   = 1'b0;
    serial_in_pin  = 1'b0;
  end
  // Each frame opens with a fresh select fall, one opcode per frame
  task automatic frame_start();
    chip_sel_n_pin = 1'b0;
    #HALF;
  endtask
  // One byte MSB first; the reply is taken at our own rising edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                      output logic [7:0] oe);
    for (int i = 7; i >= 0; i--) begin
      serial_in_pin = tx[i];
      #HALF;
      serial_clock = 1'b1;
      // A released line has no pull: show the inverse of the stale bit
      rx[i] = serial_out_oe ? serial_out_pin : ~serial_out_pin;
      oe[i] = serial_out_oe;
      #HALF;
      serial_clock = 1'b0;
    end
  endtask
  // Close the frame; the data line flips so a stale bit is never trusted
  task automatic frame_end();
    #HALF;
    chip_sel_n_pin = 1'b1;
    serial_in_pin  = ~serial_in_pin;
    #(5 * HALF);
  endtask
endmodule
`default_nettype wire

// File: bench/testbench.sv
`default_nettype none
module testbench;
  import sfp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // ******************************
  // Signals and reference state
  // ******************************
  logic        sys_clk, srst, hw_protect_pin, cs_n, sck, mosi, miso, m_oe;
  logic [7:0]  rx, oe;                 // Last byte and enables seen
  logic [7:0]  mem [int];              // Expected array contents
  logic [15:0] bnd [3] = '{16'hBFFE, 16'h5FFE, 16'h7FFE};
  int          n_errors = 0;
  int          n_checks = 0;
  int          sr_pe, sr_g, latch;     // Expected status fields

  sfp_core uut (.sys_clk(sys_clk), .srst(srst), .chip_sel_n_pin(cs_n),
    .serial_clock(sck), .serial_in_pin(mosi),
    .hw_protect_pin(hw_protect_pin), .serial_out_pin(miso),
    .serial_out_oe(m_oe));
  sfp_master u_m (.chip_sel_n_pin(cs_n), .serial_clock(sck),
    .serial_in_pin(mosi), .serial_out_pin(miso), .serial_out_oe(m_oe));

  // 125 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ******************************
  // Checking and model helpers
  // ******************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Guarded range for the present guard pair
  function automatic bit prot(input int a);
    case (sr_g)
      1: return a >= 32'h6000;
      2: return a >= 32'h4000;
      3: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [7:0] sr_exp();
    return {sr_pe[0], 3'h0, sr_g[1:0], latch[0], 1'b0};
  endfunction
  // Single-opcode frame
  task automatic cmd(input logic [7:0] op);
    u_m.frame_start();
    u_m.xfer(op, rx, oe);
    u_m.frame_end();
    if (op == OP_SET_LATCH) latch = 1;
    if (op == OP_CLR_LATCH) latch = 0;
  endtask
  task automatic sr_read();
    u_m.frame_start();
    u_m.xfer(OP_STATUS_RD, rx, oe);
    u_m.xfer(8'($urandom), rx, oe);
    u_m.frame_end();
    chk8(rx, sr_exp());
    chk8(oe, 8'hFF);
  endtask
  // Pin low here only where a scenario wants the write refused
  task automatic sr_write(input logic [7:0] v, input bit pin);
    @(posedge sys_clk) #1 hw_protect_pin = pin;
    u_m.frame_start();
    u_m.xfer(OP_STATUS_WR, rx, oe);
    u_m.xfer(v, rx, oe);
    u_m.frame_end();
    if (latch && !(sr_pe && !pin)) begin
      sr_pe = v[7];
      sr_g  = v[3:2];
    end
    latch = 0;
  endtask
  task automatic mem_write(input logic [15:0] ad, input int n, input bit sl);
    int         a;
    bit         stop;
    logic [7:0] d;
    a = ad[14:0];
    stop = 0;
    if (sl) cmd(OP_SET_LATCH);
    u_m.frame_start();
    u_m.xfer(OP_MEM_WR, rx, oe);
    u_m.xfer(ad[15:8], rx, oe);
    u_m.xfer(ad[7:0], rx, oe);
    repeat (n) begin
      d = 8'($urandom);
      u_m.xfer(d, rx, oe);
      if (!latch || prot(a)) stop = 1;
      if (!stop) begin
        mem[a] = d;
        a = (a + 1) % 32768;
      end
    end
    u_m.frame_end();
    latch = 0;
  endtask
  // Random input bytes during data show that input is ignored
  task automatic mem_read(input logic [7:0] op, input logic [15:0] ad,
                          input int n);
    int a;
    a = ad[14:0];
    u_m.frame_start();
    u_m.xfer(op, rx, oe);
    u_m.xfer(ad[15:8], rx, oe);
    u_m.xfer(ad[7:0], rx, oe);
    if (op == OP_FAST_RD) u_m.xfer(8'($urandom), rx, oe);
    repeat (n) begin
      u_m.xfer(8'($urandom), rx, oe);
      if (mem.exists(a)) chk8(rx, mem[a]);
      chk8(oe, 8'hFF);
      a = (a + 1) % 32768;
    end
    u_m.frame_end();
    chk8({7'h0, m_oe}, 8'h00);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ******************************
  // Test sequence
  // ******************************
  initial begin
    srst = 1'b1;
    hw_protect_pin = 1'b1;
    sr_pe = 0;
    sr_g = 0;
    latch = 0;
    void'($urandom(47));
    repeat (3) @(posedge sys_clk);
    #1 srst = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    sr_read();
    cmd(OP_SET_LATCH);
    sr_read();
    cmd(OP_CLR_LATCH);
    sr_read();
    sr_write(8'hFF, 1'b1);
    sr_read();
    cmd(OP_SET_LATCH);
    sr_write(8'hFF, 1'b1);
    sr_read();
    cmd(OP_SET_LATCH);
    sr_write(8'h00, 1'b0);
    sr_read();
    $display("test status done");
    // Every guard pair against its boundaries, pin low while writing
    for (int g = 0; g < 4; g++) begin
      cmd(OP_SET_LATCH);
      sr_write({1'b1, 3'($urandom), g[1:0], 2'($urandom)}, 1'b1);
      sr_read();
      @(posedge sys_clk) #1 hw_protect_pin = 1'b0;
      if (g == 0) begin
        mem_write(16'h0010, 2, 1'b1);
        mem_write(16'h0010, 2, 1'b0);
        mem_read(OP_MEM_RD, 16'h0010, 2);
      end
      for (int k = 0; k < 3; k++) begin
        mem_write(bnd[k], 4, 1'b1);
        mem_read(OP_MEM_RD, bnd[k], 4);
        mem_read(OP_FAST_RD, bnd[k] ^ 16'h8000, 4);
      end
      $display("test guard %0d done", g);
    end
    // Unknown opcode keeps the output released
    cmd(OP_SET_LATCH);
    u_m.frame_start();
    u_m.xfer(8'hA5, rx, oe);
    repeat (2) begin
      u_m.xfer(OP_STATUS_RD, rx, oe);
      chk8(oe, 8'h00);
    end
    u_m.frame_end();
    $display("test unknown_opcode done");
    results();
  end
  // Watchdog: about one and a half times the expected run
  initial begin
    #700000;
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
